/* File: logic/sefe_pkg.sv */
package sefe_pkg;

    // ************************************************************
    // Instruction codes
    // ************************************************************
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;

    // ************************************************************
    // Status word layout and reset values
    // ************************************************************
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_BP_LSB = 2;
    localparam int SR_PIN_EN_BIT = 7;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic PIN_EN_RESET = 1'b0;
    localparam logic WEL_RESET = 1'b0;

    // ************************************************************
    // Array shape and timing
    // ************************************************************
    localparam int MEM_BYTES_DEF = 8192;
    localparam int PAGE_BYTES_DEF = 32;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYC_DEF = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_WAIT} sefe_state_type;

endpackage

/* File: logic/sefe_bit_if.sv */
`timescale 1ns/100ps
interface sefe_bit_if;
    logic start;
    logic rx_fire;
    logic [7:0] rx_data;
    logic at_bound;
    logic pause;
    logic [7:0] tx_byte;
    logic tx_en;

    modport link (
        output start,
        output rx_fire,
        output rx_data,
        output at_bound,
        output pause,
        input tx_byte,
        input tx_en
    );

    modport core (
        input start,
        input rx_fire,
        input rx_data,
        input at_bound,
        input pause,
        output tx_byte,
        output tx_en
    );
endinterface

/* File: logic/sefe_mem.sv */
`timescale 1ns/100ps
module sefe_mem #(
    parameter int MEM_BYTES = 8192,
    parameter int AW = 13
) (
    // Write port, system clock
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port, combinational
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [MEM_BYTES];

    // Writes only land during the self-timed cycle, so reads see stable data
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata; // RULE10
        end
    end

    assign rdata = mem[raddr];
endmodule // sefe_mem

/* File: logic/sefe_link.sv */
`timescale 1ns/100ps
module sefe_link
    import sefe_pkg::*;
(
    // Serial pins
    input wire logic sck,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    // Serial output
    output logic so,
    output logic so_oe,
    // Byte side
    sefe_bit_if.link bus
);
    logic link_clr_n;
    logic fresh_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [2:0] cnt_now;
    logic pause;
    logic step;
    logic drive_reg;

    // Deselect clears the frame flag and floats the output
    assign link_clr_n = rst_n & ~cs_n;
    assign pause = ~hold_n & ~fresh_reg; // RULE3
    assign step = ~cs_n & ~pause; // RULE7 RULE8
    assign cnt_now = fresh_reg ? 3'h0 : bit_cnt_reg;
    assign bus.start = step & fresh_reg;
    assign bus.rx_fire = step & (cnt_now == 3'h7);
    assign bus.rx_data = {shift_reg, si}; // RULE1
    assign bus.at_bound = (bit_cnt_reg == 3'h0);
    assign bus.pause = pause;
    // Gated by the pause itself so the line floats and returns while the clock is low
    assign so_oe = drive_reg & ~pause; // RULE9

    always_ff @(posedge sck or negedge link_clr_n) begin
        if (!link_clr_n) begin
            fresh_reg <= 1'b1;
        end else if (step) begin
            fresh_reg <= 1'b0;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
        end else if (step) begin
            bit_cnt_reg <= cnt_now + 3'h1; // RULE6
            shift_reg <= {shift_reg[5:0], si}; // RULE1
        end
    end

    always_ff @(negedge sck or negedge link_clr_n) begin
        if (!link_clr_n) begin
            so <= 1'b0;
            drive_reg <= 1'b0; // RULE17
        end else begin
            so <= bus.tx_byte[~bit_cnt_reg]; // RULE2
            drive_reg <= bus.tx_en & ~fresh_reg;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_capture;
        @(posedge sck) disable iff (!rst_n) step |=> shift_reg[0] == $past(si);
    endproperty
    a_capture: assert property (p_capture) else $error("input bit not captured"); // RULE1

    property p_so_bit;
        @(posedge sck) disable iff (!link_clr_n) so_oe |-> so == bus.tx_byte[~bit_cnt_reg];
    endproperty
    a_so_bit: assert property (p_so_bit) else $error("output bit wrong at rising edge"); // RULE2

    property p_freeze;
        @(posedge sck) disable iff (!rst_n) (!cs_n && pause) |=> $stable(bit_cnt_reg) && $stable(shift_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("shift advanced while paused"); // RULE7

    property p_ignore;
        @(posedge sck) disable iff (!rst_n) (!cs_n && !so_oe && pause) ##1 pause |-> $stable(shift_reg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("input taken while output floats"); // RULE8

    property p_release;
        @(posedge sck) disable iff (!link_clr_n) (pause && $past(pause)) |-> !so_oe && $stable(so);
    endproperty
    a_release: assert property (p_release) else $error("output driven while paused"); // RULE9
endmodule // sefe_link

/* File: logic/sefe_top.sv */
`timescale 1ns/100ps
// What this block does
// RULE1: Capture serial input on rising clock edges.
// RULE2: Change serial output only on falling edges.
// RULE3: Pause acts only while selected and mid-sequence.
// RULE4: Host lowers pause only while clock low.
// RULE5: Host raises pause only while clock low.
// RULE6: Pause keeps position, instruction, address intact.
// RULE7: Clock edges during pause advance nothing.
// RULE8: Ignore input while output floats in pause.
// RULE9: Float output while paused, drive after.
// RULE10: Array holds 4096 or 8192 eight-bit bytes.
// RULE11: Respond only while selected, three-wire access.
// RULE12: Programming self-timed, no separate erase needed.
// RULE13: Four protection settings block protected writes.
// RULE14: Enable and disable instructions gate programming.
// RULE15: Protect pin guards status register writes.
// RULE16: Protect low with pin enable rejects writes; the code blocks only status register writes, not array writes.
// RULE17: Deselected: accept no input, output floats.
module sefe_top
    import sefe_pkg::*;
#(
    parameter int MEM_BYTES = MEM_BYTES_DEF,
    parameter int PAGE_BYTES = PAGE_BYTES_DEF,
    parameter int WRITE_CYC = WRITE_CYC_DEF
) (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    output logic so,
    output logic so_oe,
    // Protection and state
    input wire logic wp_n,
    output logic busy
);
    localparam int AW = $clog2(MEM_BYTES);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam int TW = $clog2(WRITE_CYC + 1);

    function automatic logic is_protected(input logic [AW-1:0] a, input logic [1:0] bp);
        logic hit;
        unique case (bp)
            2'h0: hit = 1'b0;
            2'h1: hit = &a[AW-1 -: 2];
            2'h2: hit = a[AW-1];
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // ************************************************************
    // Link side, serial clock domain
    // ************************************************************
    sefe_bit_if bus ();

    logic [7:0] op_reg;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [15:0] addr_step;
    logic [15:0] rd_addr;
    logic [1:0] idx_reg;
    logic [7:0] sr_data_reg;
    logic [7:0] pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask_reg;
    logic frame_tgl_reg;
    logic [7:0] tx_byte_reg;
    logic tx_en_reg;
    logic [7:0] stat_s1_reg;
    logic [7:0] stat_s2_reg;
    logic [7:0] rd_data;
    logic [7:0] tx_next;
    logic [PW-1:0] wr_slot;
    logic is_rdsr_now;
    logic is_read;
    logic tx_load;
    logic wr_fire;

    sefe_link u_link (
        .sck(sck),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .si(si),
        .hold_n(hold_n),
        .so(so),
        .so_oe(so_oe),
        .bus(bus)
    );

    assign bus.tx_byte = tx_byte_reg;
    assign bus.tx_en = tx_en_reg;

    // Decode of the byte that completes on this rising edge
    assign rd_addr = (idx_reg == 2'h2) ? {addr_reg[15:8], bus.rx_data} : addr_reg;
    assign is_rdsr_now = ((idx_reg == 2'h0) & (bus.rx_data == OP_RDSR)) | ((idx_reg != 2'h0) & (op_reg == OP_RDSR));
    assign is_read = (op_reg == OP_READ) & (idx_reg >= 2'h2);
    assign tx_load = bus.rx_fire & (is_rdsr_now | is_read);
    assign tx_next = is_rdsr_now ? stat_s2_reg : rd_data;
    assign wr_slot = addr_reg[PW-1:0];
    assign wr_fire = bus.rx_fire & (op_reg == OP_WRITE) & (idx_reg == 2'h3);

    // Writes wrap inside the page, reads run on through the array
    assign addr_step = (op_reg == OP_WRITE) ? {addr_reg[15:PW], wr_slot + PW'(1)} : addr_reg + 16'h0001;
    assign addr_next = (idx_reg == 2'h1) ? {bus.rx_data, addr_reg[7:0]} :
                       (idx_reg == 2'h2) ? rd_addr + {15'h0000, is_read} :
                       (idx_reg == 2'h3) ? addr_step : addr_reg;

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= 8'h00;
            addr_reg <= 16'h0000;
            idx_reg <= 2'h0;
            sr_data_reg <= 8'h00;
            frame_tgl_reg <= 1'b0;
        end else if (bus.start) begin
            idx_reg <= 2'h0;
            frame_tgl_reg <= ~frame_tgl_reg;
        end else if (bus.rx_fire) begin
            idx_reg <= (idx_reg == 2'h3) ? idx_reg : idx_reg + 2'h1; // RULE6
            op_reg <= (idx_reg == 2'h0) ? bus.rx_data : op_reg;
            sr_data_reg <= (idx_reg == 2'h1) ? bus.rx_data : sr_data_reg;
            addr_reg <= addr_next;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            pmask_reg <= '0;
            tx_byte_reg <= 8'h00;
            tx_en_reg <= 1'b0;
        end else if (bus.start) begin
            pmask_reg <= '0;
            tx_en_reg <= 1'b0;
        end else begin
            if (wr_fire) begin
                pmask_reg[wr_slot] <= 1'b1;
            end
            if (tx_load) begin
                tx_byte_reg <= tx_next;
                tx_en_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sck) begin
        if (wr_fire) begin
            pbuf[wr_slot] <= bus.rx_data;
        end
    end

    // ************************************************************
    // Core side, system clock domain
    // ************************************************************
    sefe_state_type state_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic wp_s1_reg;
    logic wp_s2_reg;
    logic seen_reg;
    logic busy_reg;
    logic wel_reg;
    logic pin_en_reg;
    logic [1:0] bp_reg;
    logic [PW-1:0] slot_reg;
    logic [TW-1:0] timer_reg;
    logic [7:0] status_word;
    logic cs_rise;
    logic cmd_ok;
    logic do_wren;
    logic do_wrdi;
    logic wrsr_go;
    logic write_go;
    logic page_prot;
    logic sr_locked;
    logic prog_last;
    logic wait_done;
    logic mem_we;
    logic [AW-1:0] mem_waddr;

    // Deselect and protect pin cross in through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            wp_s1_reg <= wp_n;
            wp_s2_reg <= wp_s1_reg;
        end
    end

    // Frame record is still once the clock has stopped and select is high
    assign cs_rise = cs_s2_reg & ~cs_s3_reg;
    assign cmd_ok = cs_rise & (frame_tgl_reg ^ seen_reg) & bus.at_bound & (state_reg == ST_IDLE);
    assign do_wren = cmd_ok & (op_reg == OP_WREN) & (idx_reg == 2'h1);
    assign do_wrdi = cmd_ok & (op_reg == OP_WRDI) & (idx_reg == 2'h1);
    assign sr_locked = pin_en_reg & ~wp_s2_reg; // RULE15 RULE16
    assign wrsr_go = cmd_ok & (op_reg == OP_WRSR) & (idx_reg >= 2'h2) & wel_reg & ~sr_locked; // RULE14
    assign page_prot = is_protected(addr_reg[AW-1:0], bp_reg); // RULE13
    assign write_go = cmd_ok & (op_reg == OP_WRITE) & (idx_reg == 2'h3) & (|pmask_reg) & wel_reg & ~page_prot;
    assign prog_last = (state_reg == ST_PROG) & (slot_reg == PW'(PAGE_BYTES - 1));
    assign wait_done = (state_reg == ST_WAIT) & (timer_reg == TW'(WRITE_CYC - 1)); // RULE12
    assign mem_we = (state_reg == ST_PROG) & pmask_reg[slot_reg]; // RULE12
    assign mem_waddr = {addr_reg[AW-1:PW], slot_reg};
    assign busy = busy_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            slot_reg <= '0;
            timer_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    slot_reg <= '0;
                    timer_reg <= '0;
                    if (write_go) begin
                        state_reg <= ST_PROG;
                        busy_reg <= 1'b1;
                    end else if (wrsr_go) begin
                        state_reg <= ST_WAIT;
                        busy_reg <= 1'b1;
                    end
                end
                ST_PROG: begin
                    slot_reg <= slot_reg + PW'(1);
                    if (prog_last) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    timer_reg <= timer_reg + TW'(1);
                    if (wait_done) begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wel_reg <= WEL_RESET;
            pin_en_reg <= PIN_EN_RESET;
            bp_reg <= BP_RESET;
            seen_reg <= 1'b0;
        end else begin
            wel_reg <= do_wren | (wel_reg & ~do_wrdi & ~wait_done); // RULE14
            if (wrsr_go) begin
                pin_en_reg <= sr_data_reg[SR_PIN_EN_BIT];
                bp_reg <= sr_data_reg[SR_BP_LSB +: 2]; // RULE13
            end
            if (cs_rise) begin
                seen_reg <= frame_tgl_reg;
            end
        end
    end

    always_comb begin
        status_word = 8'h00;
        status_word[SR_BUSY_BIT] = busy_reg;
        status_word[SR_WEL_BIT] = wel_reg;
        status_word[SR_BP_LSB +: 2] = bp_reg;
        status_word[SR_PIN_EN_BIT] = pin_en_reg;
    end

    // Status crosses back to the serial clock for the status read
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            stat_s1_reg <= 8'h00;
            stat_s2_reg <= 8'h00;
        end else begin
            stat_s1_reg <= status_word;
            stat_s2_reg <= stat_s1_reg;
        end
    end

    sefe_mem #(
        .MEM_BYTES(MEM_BYTES),
        .AW(AW)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(pbuf[slot_reg]),
        .raddr(rd_addr[AW-1:0]),
        .rdata(rd_data)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    property p_pause_keep;
        @(posedge sck) disable iff (!rst_n) (!cs_n && bus.pause) |=> $stable(op_reg) && $stable(addr_reg) && $stable(idx_reg);
    endproperty
    a_pause_keep: assert property (p_pause_keep) else $error("frame state moved while paused"); // RULE6

    property p_deselect;
        @(posedge clk) disable iff (!rst_n) cs_s2_reg |-> !so_oe;
    endproperty
    a_deselect: assert property (p_deselect) else $error("output driven while deselected"); // RULE11 RULE17

    property p_need_enable;
        @(posedge clk) disable iff (!rst_n) (cmd_ok && !wel_reg) |=> (state_reg == ST_IDLE) && !busy_reg;
    endproperty
    a_need_enable: assert property (p_need_enable) else $error("program started without enable"); // RULE14

    property p_sr_lock;
        @(posedge clk) disable iff (!rst_n) (cmd_ok && op_reg == OP_WRSR && pin_en_reg && !wp_s2_reg) |=> !busy_reg && $stable(bp_reg);
    endproperty
    a_sr_lock: assert property (p_sr_lock) else $error("status write passed locked pin"); // RULE16

    property p_block;
        @(posedge clk) disable iff (!rst_n) mem_we |-> !is_protected(mem_waddr, bp_reg);
    endproperty
    a_block: assert property (p_block) else $error("write into protected block"); // RULE13

    property p_selftimed;
        @(posedge clk) disable iff (!rst_n) $rose(busy_reg) |-> busy_reg [*8];
    endproperty
    a_selftimed: assert property (p_selftimed) else $error("write cycle ended too soon"); // RULE12

    property p_cycle_end;
        @(posedge clk) disable iff (!rst_n) wait_done |=> !busy_reg && !wel_reg && (state_reg == ST_IDLE);
    endproperty
    a_cycle_end: assert property (p_cycle_end) else $error("write cycle did not close"); // RULE12

    c_pause: cover property (@(posedge sck) disable iff (!rst_n) !cs_n && bus.pause ##1 !bus.pause);
    c_write: cover property (@(posedge clk) disable iff (!rst_n) write_go);
    c_wrsr: cover property (@(posedge clk) disable iff (!rst_n) wrsr_go);
    c_read: cover property (@(posedge sck) disable iff (!rst_n) tx_load && is_read);
endmodule // sefe_top

/* File: dv/sefe_host.sv */
`timescale 1ns/100ps
module sefe_host (
    // Serial pins toward the memory
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    // Resolved serial output line
    input wire logic so_line
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end

    // ************************************************************
    // Pause with junk clocks and junk input data
    // ************************************************************
    task automatic pause();
        hold_n = 1'b0;
        repeat (3) begin
            si = ~si;
            #3.75 sck = 1'b1;
            #7.5 sck = 1'b0;
            #3.75;
        end
        hold_n = 1'b1;
    endtask

    // ************************************************************
    // One frame, optional pause inside byte hold_at
    // ************************************************************
    task automatic run(input int hold_at);
        logic [7:0] r;
        rxq.delete();
        #1 cs_n = 1'b0;
        #20;
        foreach (txq[k]) begin
            for (int i = 7; i >= 0; i--) begin
                if (k == hold_at && i == 3) pause();
                si = txq[k][i];
                #3.75 sck = 1'b1;
                r = {r[6:0], so_line};
                #7.5 sck = 1'b0;
                #3.75;
            end
            rxq.push_back(r);
        end
        #20 cs_n = 1'b1;
        // Released line shows no stale value
        si = ~si;
        #100;
    endtask
endmodule // sefe_host

/* File: dv/sefe_bench.sv */
`timescale 1ns/100ps
module sefe_bench
    import sefe_pkg::*;
;
    localparam int M = 4096;
    localparam int WC = 50;
    logic clk, rst_n, wp_n, sck, cs_n, si, hold_n, so, so_oe, busy, so_line;
    logic so_last = 1'b0;
    logic [7:0] mem[int];
    int fails = 0;
    int checks = 0;
    int hold_cnt = 0;
    int base;

    sefe_top #(.MEM_BYTES(M), .PAGE_BYTES(32), .WRITE_CYC(WC)) uut (
        .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so(so), .so_oe(so_oe), .wp_n(wp_n), .busy(busy)
    );
    sefe_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_line(so_line));

    // Floating line shows the inverse of its last driven value
    always @(so or so_oe) begin
        if (so_oe) so_last = so;
    end
    assign so_line = so_oe ? so : ~so_last;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ************************************************************
    // Checking and verdict
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Second clock of a pause and later: output must float
    always @(posedge sck) begin
        if (!hold_n && !cs_n) begin
            if (hold_cnt > 0) check(so_oe, 1'b0);
            hold_cnt++;
        end else begin
            hold_cnt = 0;
        end
    end

    function automatic int lim(input int bp);
        case (bp)
            0: return M;
            1: return M * 3 / 4;
            2: return M / 2;
            default: return 0;
        endcase
    endfunction

    // ************************************************************
    // Frame level tasks
    // ************************************************************
    task automatic xfer(input int h);
        host.run(h);
        check(so_oe, 1'b0);
    endtask

    task automatic wren();
        host.txq = '{OP_WREN};
        xfer(-1);
    endtask

    task automatic rdsr(input logic [7:0] exp);
        host.txq = '{OP_RDSR, 8'h00};
        xfer(-1);
        check(host.rxq[1], exp);
    endtask

    task automatic finish_wr(input bit ok);
        @(negedge clk);
        check(busy, ok);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
        @(negedge clk);
        check(busy, 1'b0);
    endtask

    task automatic wrsr(input logic [7:0] v, input bit ok);
        wren();
        host.txq = '{OP_WRSR, v};
        xfer(-1);
        finish_wr(ok);
    endtask

    task automatic wr(input int a, input int n, input bit en, input bit ok);
        logic [7:0] d;
        int p;
        if (en) wren();
        host.txq = '{OP_WRITE, 8'(a >> 8), 8'(a)};
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            p = (a & ~31) | ((a + i) & 31);
            host.txq.push_back(d);
            if (ok) mem[p] = d;
        end
        xfer(-1);
        finish_wr(ok);
    endtask

    task automatic rd(input int a, input int n, input int h);
        int p;
        host.txq = '{OP_READ, 8'(a >> 8), 8'(a)};
        repeat (n) host.txq.push_back(8'h00);
        xfer(h);
        for (int i = 0; i < n; i++) begin
            p = (a + i) & (M - 1);
            if (mem.exists(p)) check(host.rxq[3 + i], mem[p]);
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        void'($urandom(32'h8f32));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdsr(8'h00);
        wren();
        rdsr(8'h02);
        host.txq = '{OP_WRDI};
        xfer(-1);
        rdsr(8'h00);
        @(posedge clk);
        wp_n <= 1'b0;
        for (int bp = 0; bp < 4; bp++) begin
            wrsr(8'(bp << 2), 1'b1);
            rdsr(8'(bp << 2));
            for (int k = 0; k < 3; k++) begin
                base = (k == 0) ? 0 : (k == 1) ? M / 2 : M - 32;
                wr(base + $urandom_range(31), bp == 0 ? 32 : 4, 1'b1, base < lim(bp));
                rd(base, 32, k + 1);
            end
        end
        wrsr(8'h00, 1'b1);
        wr(M / 2, 4, 1'b0, 1'b0);
        rd(M / 2, 32, -1);
        rd(2 * M - 1, 2, 0);
        wrsr(8'h80, 1'b1);
        rdsr(8'h80);
        wrsr(8'h84, 1'b0);
        rdsr(8'h82);
        @(posedge clk);
        wp_n <= 1'b1;
        wrsr(8'h00, 1'b1);
        rdsr(8'h00);
        print_verdict();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule // sefe_bench
